// ### inc/hbs_pkg.sv
// Package for the holding brake sequencer: register map, field codes,
// timing constants and the sequencer state type.
// Assumes a 40 MHz system clock and a 32-bit Avalon-MM register port.
package hbs_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    // Register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_TIMING = 4'h4;
    localparam logic [3:0] REG_DECEL = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hC;
    // Control fields
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_COAST_BIT = 1;
    localparam int CTRL_FUNC_LSB = 8;
    localparam int CTRL_DO_LSB = 16;
    localparam int CTRL_ZSPD_LSB = 24;
    // Digital input and output function codes
    localparam logic [7:0] FN_SERVO_ON = 8'h01;
    localparam logic [7:0] FN_QUICK_STOP = 8'h47;
    localparam logic [7:0] FN_ON_BRAKE = 8'h48;
    localparam logic [7:0] FN_BRAKE_CTRL = 8'h08;
    // Delays kept in milliseconds
    localparam logic [15:0] APPLY_DFLT_MS = 16'h0064;
    localparam logic [15:0] RELEASE_DFLT_MS = 16'h0064;
    localparam logic [7:0] ZSPD_DFLT = 8'h0A;
    localparam logic [15:0] DECEL_DFLT_MS = 16'h00C8;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned CLK_NS = 1000000000 / CLK_HZ;
    localparam logic [15:0] MS_CYCLES = 16'(MS_NS / CLK_NS);
    localparam logic [31:0] REG_RESET_VAL = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_VAL = 32'hDEAD_BEEF;
    typedef enum logic [2:0] {
        ST_OFF, ST_RELEASE, ST_RUN, ST_DECEL, ST_ZERO_WAIT, ST_APPLY
    } hbs_state_type;
endpackage

// ### logic/hbs_top.sv
// Holding brake sequencer: runs the enable, deceleration, brake apply and
// disable sequence from one enable-type digital input; quick stop mode also needs the second enable input.
// Assumes a motor speed magnitude from the power stage and Avalon-MM access.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module hbs_top (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Digital inputs and power stage
    input wire logic digital_input_line_i,
    input wire logic second_enable_i,
    input wire logic [7:0] speed_mag_i,
    // Drive outputs
    output logic brake_release_o,
    output logic motor_enable_o,
    output logic motion_allow_o,
    output logic decel_cmd_o,
    output logic dyn_brake_o,
    output logic alarm_o
);
    logic auto_r;
    logic coast_r;
    logic [7:0] func_r;
    logic [7:0] do_func_r;
    logic [7:0] zspd_r;
    logic [15:0] apply_r;
    logic [15:0] release_r;
    logic [15:0] decel_r;
    logic [2:0] din_sync_r;
    logic [2:0] en2_sync_r;
    logic din_r;
    logic en2_r;
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic quick_r;
    logic ack_r;
    hbs_pkg::hbs_state_type state_r;
    hbs_pkg::hbs_state_type state_nxt;
    logic req_on;
    logic at_zero;
    logic wr_ok;

    function automatic logic [31:0] ms_to_cyc(input logic [15:0] ms);
        ms_to_cyc = 32'(ms) * 32'(hbs_pkg::MS_CYCLES);
    endfunction

    // Apply delay is held signed and counted as its magnitude; it stands for a negative offset
    function automatic logic [15:0] apply_mag(input logic [15:0] v);
        apply_mag = v[15] ? 16'(-v) : v;
    endfunction

    // Pin inputs: three stages, a change counts when stages two and three agree
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            din_sync_r <= 3'h0;
            en2_sync_r <= 3'h0;
            din_r <= 1'b0;
            en2_r <= 1'b0;
        end else begin
            din_sync_r <= {din_sync_r[1:0], digital_input_line_i};
            en2_sync_r <= {en2_sync_r[1:0], second_enable_i};
            if (din_sync_r[1] == din_sync_r[2]) begin
                din_r <= din_sync_r[2];
            end
            if (en2_sync_r[1] == en2_sync_r[2]) begin
                en2_r <= en2_sync_r[2];
            end
        end
    end

    // Quick stop line is active low stop; enabling comes from the second input
    always_comb begin
        unique case (func_r)
            hbs_pkg::FN_QUICK_STOP: req_on = en2_r && din_r;
            hbs_pkg::FN_ON_BRAKE: req_on = din_r;
            default: req_on = din_r;
        endcase
    end

    assign at_zero = speed_mag_i <= zspd_r;
    assign wr_ok = (state_r == hbs_pkg::ST_OFF);

    // Register bus: one wait cycle on every access
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read_i || avs_write_i) && !ack_r;
        end
    end
    // Flop copy of !ack_r, so the bus sees a clean register output
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_r);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            auto_r <= 1'b0;
            coast_r <= 1'b0;
            func_r <= hbs_pkg::FN_SERVO_ON;
            do_func_r <= 8'h00;
            zspd_r <= 8'h00;
            apply_r <= 16'h0000;
            release_r <= 16'h0000;
            decel_r <= hbs_pkg::DECEL_DFLT_MS;
        end else if (avs_write_i && ack_r && wr_ok) begin
            unique case (avs_address_i)
                hbs_pkg::REG_CTRL: begin
                    auto_r <= avs_writedata_i[hbs_pkg::CTRL_AUTO_BIT];
                    coast_r <= avs_writedata_i[hbs_pkg::CTRL_COAST_BIT];
                    func_r <= avs_writedata_i[hbs_pkg::CTRL_FUNC_LSB +: 8];
                    if (avs_writedata_i[hbs_pkg::CTRL_AUTO_BIT] && !auto_r) begin
                        do_func_r <= hbs_pkg::FN_BRAKE_CTRL;
                        apply_r <= 16'(-hbs_pkg::APPLY_DFLT_MS);
                        release_r <= hbs_pkg::RELEASE_DFLT_MS;
                        zspd_r <= hbs_pkg::ZSPD_DFLT;
                    end else begin
                        do_func_r <= avs_writedata_i[hbs_pkg::CTRL_DO_LSB +: 8];
                        zspd_r <= avs_writedata_i[hbs_pkg::CTRL_ZSPD_LSB +: 8];
                    end
                end
                hbs_pkg::REG_TIMING: begin
                    apply_r <= avs_writedata_i[15:0];
                    release_r <= avs_writedata_i[31:16];
                end
                hbs_pkg::REG_DECEL: decel_r <= avs_writedata_i[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            avs_readdata_o <= hbs_pkg::REG_RESET_VAL;
        end else if (avs_read_i && !ack_r) begin
            unique case (avs_address_i)
                hbs_pkg::REG_CTRL: avs_readdata_o <= {zspd_r, do_func_r,
                    func_r, 6'h00, coast_r, auto_r};
                hbs_pkg::REG_TIMING: avs_readdata_o <= {release_r, apply_r};
                hbs_pkg::REG_DECEL: avs_readdata_o <= {16'h0000, decel_r};
                hbs_pkg::REG_STATUS: avs_readdata_o <= {24'h000000, alarm_o,
                    motor_enable_o, brake_release_o, 2'h0, 3'(state_r)};
                default: avs_readdata_o <= hbs_pkg::UNMAPPED_VAL;
            endcase
        end
    end

    // Sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = (cnt_r != 32'h0) ? cnt_r - 32'h1 : 32'h0;
        unique case (state_r)
            hbs_pkg::ST_OFF: if (req_on && !alarm_o) begin
                state_nxt = hbs_pkg::ST_RELEASE;
                cnt_nxt = ms_to_cyc(release_r);
            end
            hbs_pkg::ST_RELEASE: if (!req_on) begin
                state_nxt = hbs_pkg::ST_DECEL;
                cnt_nxt = ms_to_cyc(decel_r);
            end else if (cnt_r == 32'h0) begin
                state_nxt = hbs_pkg::ST_RUN;
            end
            hbs_pkg::ST_RUN: if (!req_on) begin
                state_nxt = hbs_pkg::ST_DECEL;
                cnt_nxt = ms_to_cyc(decel_r);
            end
            hbs_pkg::ST_DECEL: if (at_zero) begin
                state_nxt = hbs_pkg::ST_APPLY;
                cnt_nxt = ms_to_cyc(apply_mag(apply_r));
            end else if (cnt_r == 32'h0) begin
                state_nxt = hbs_pkg::ST_ZERO_WAIT;
            end
            hbs_pkg::ST_ZERO_WAIT: if (at_zero) begin
                state_nxt = hbs_pkg::ST_APPLY;
                cnt_nxt = ms_to_cyc(apply_mag(apply_r));
            end
            hbs_pkg::ST_APPLY: if (cnt_r == 32'h0) begin
                state_nxt = hbs_pkg::ST_OFF;
            end
            default: state_nxt = hbs_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_r <= hbs_pkg::ST_OFF;
            cnt_r <= 32'h0;
            quick_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            // Every stop entry rewrites the cause, so no stale quick stop
            if (state_nxt == hbs_pkg::ST_DECEL &&
                state_r != hbs_pkg::ST_DECEL) begin
                quick_r <= (func_r == hbs_pkg::FN_QUICK_STOP) && en2_r;
            end
        end
    end

    // Outputs registered from next state
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            motor_enable_o <= 1'b0;
            brake_release_o <= 1'b0;
            motion_allow_o <= 1'b0;
            decel_cmd_o <= 1'b0;
            dyn_brake_o <= 1'b0;
        end else begin
            motor_enable_o <= state_nxt != hbs_pkg::ST_OFF;
            brake_release_o <= (do_func_r == hbs_pkg::FN_BRAKE_CTRL) &&
                (state_nxt inside {hbs_pkg::ST_RELEASE, hbs_pkg::ST_RUN,
                hbs_pkg::ST_DECEL, hbs_pkg::ST_ZERO_WAIT});
            motion_allow_o <= state_nxt == hbs_pkg::ST_RUN;
            decel_cmd_o <= state_nxt inside {hbs_pkg::ST_DECEL,
                hbs_pkg::ST_ZERO_WAIT};
            // Servo-on decel is a dynamic brake unless coast is chosen
            dyn_brake_o <= (func_r == hbs_pkg::FN_SERVO_ON) && !coast_r &&
                (state_nxt == hbs_pkg::ST_DECEL);
        end
    end

    // Alarm holds until a write of the status register clears it
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            alarm_o <= 1'b0;
        end else if (state_r == hbs_pkg::ST_APPLY &&
                     state_nxt == hbs_pkg::ST_OFF && quick_r) begin
            alarm_o <= 1'b1;
        end else if (avs_write_i && ack_r &&
                     avs_address_i == hbs_pkg::REG_STATUS) begin
            alarm_o <= 1'b0;
        end
    end

    chk_apply_wait: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        state_r == hbs_pkg::ST_APPLY |-> motor_enable_o)
        else $error("motor disabled before apply delay ended");
    chk_brake_at_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(state_r == hbs_pkg::ST_APPLY) |-> !brake_release_o && at_zero)
        else $error("brake apply without zero speed");
    chk_no_motion_decel: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        decel_cmd_o |-> !motion_allow_o)
        else $error("motion allowed during decel");
    chk_release_delay: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(motion_allow_o) |-> $past(state_r) == hbs_pkg::ST_RELEASE)
        else $error("motion before release delay");
    chk_alarm_cause: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(alarm_o) |-> quick_r && state_r == hbs_pkg::ST_OFF)
        else $error("alarm without quick stop");
    chk_write_locked: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !wr_ok |=> $stable(apply_r) && $stable(decel_r))
        else $error("settings changed while enabled");
    chk_dyn_brake: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        dyn_brake_o |-> !coast_r && func_r == hbs_pkg::FN_SERVO_ON)
        else $error("dynamic brake in wrong mode");
    chk_auto_default: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(auto_r) |-> do_func_r == hbs_pkg::FN_BRAKE_CTRL &&
        apply_r != 16'h0000 && release_r != 16'h0000)
        else $error("auto brake defaults missing");
    chk_zero_window: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        state_r == hbs_pkg::ST_ZERO_WAIT && !at_zero |=>
        state_r == hbs_pkg::ST_ZERO_WAIT)
        else $error("left zero wait above window");
    chk_decel_cause: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) $rose(decel_cmd_o) |-> !$past(req_on))
        else $error("decel without enable going off");
    chk_brake_powered: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) brake_release_o |-> motor_enable_o)
        else $error("brake released with motor off");
    chk_alarm_blocks: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) alarm_o && state_r == hbs_pkg::ST_OFF |=>
        state_r == hbs_pkg::ST_OFF) else $error("enabled while alarm set");
    chk_quick_enable: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) func_r == hbs_pkg::FN_QUICK_STOP && !en2_r &&
        state_r == hbs_pkg::ST_OFF |=> state_r == hbs_pkg::ST_OFF)
        else $error("quick stop mode enabled without second input");
endmodule
`default_nettype wire

// ### dv/hbs_motor_model.sv
// Motor speed model for the brake sequencer bench.
// Assumes the sequencer's clock; speed follows its enable and decel outputs.
`timescale 1ns/10ps
`default_nettype none
module hbs_motor_model #(
    parameter logic [7:0] RUN_SPD = 8'h80
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Drive commands
    input wire logic motor_enable_i,
    input wire logic motion_allow_i,
    input wire logic decel_cmd_i,
    // Speed feedback
    output logic [7:0] speed_mag_o
);
    // One step a cycle, so zero speed is reached gradually, not at once
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            speed_mag_o <= 8'h00;
        end else if (motion_allow_i && !decel_cmd_i && speed_mag_o != RUN_SPD) begin
            speed_mag_o <= speed_mag_o + 8'h01;
        end else if ((decel_cmd_i || !motor_enable_i) && speed_mag_o != 8'h00) begin
            speed_mag_o <= speed_mag_o - 8'h01;
        end
    end
endmodule
`default_nettype wire

// ### dv/hbs_top_tb.sv
// Self-checking bench for the holding brake sequencer.
// Assumes the motor model in the same folder and the register map package.
`timescale 1ns/10ps
`default_nettype none
module hbs_top_tb;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wait_rq;
    logic din = 1'b0;
    logic en2 = 1'b0;
    logic [7:0] spd;
    logic brk, mot, mov, dec, dyn, alm;
    logic [31:0] rv;
    int error_cnt = 0;
    int cmp_count = 0;
    int c;

    hbs_top i_dut (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdat), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wait_rq), .digital_input_line_i(din),
        .second_enable_i(en2), .speed_mag_i(spd),
        .brake_release_o(brk), .motor_enable_o(mot),
        .motion_allow_o(mov), .decel_cmd_o(dec),
        .dyn_brake_o(dyn), .alarm_o(alm)
    );
    hbs_motor_model i_motor (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .motor_enable_i(mot), .motion_allow_i(mov),
        .decel_cmd_i(dec), .speed_mag_o(spd)
    );

    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One Avalon word; a read leaves its data in rv
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk_i);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk_i);
            if (wait_rq === 1'b0) break;
        end
        rv = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n == 50) begin
            error_cnt++;
            report_and_stop();
        end
    endtask

    // Index: 0 brake, 1 motor, 2 motion, 3 decel, 4 dyn brake, 5 alarm
    task automatic wait_on(input int i, input logic v, output int cnt);
        logic [5:0] o;
        for (cnt = 0; cnt < 60000; cnt++) begin
            @(posedge sys_clk_i);
            o = {alm, dyn, dec, mov, mot, brk};
            if (o[i] === v) break;
        end
        if (cnt == 60000) begin
            error_cnt++;
            report_and_stop();
        end
    endtask

    task automatic set_in(input logic d, input logic e);
        @(posedge sys_clk_i);
        din <= d;
        en2 <= e;
    endtask

    task automatic t_regs();
        bus(1'b0, hbs_pkg::REG_DECEL, 32'h0);
        check(rv, {16'h0000, hbs_pkg::DECEL_DFLT_MS});
        bus(1'b0, hbs_pkg::REG_TIMING, 32'h0);
        check(rv, 32'h0000_0000);
        bus(1'b0, 4'h2, 32'h0);
        check(rv, hbs_pkg::UNMAPPED_VAL);
    endtask

    task automatic t_auto();
        bus(1'b1, hbs_pkg::REG_CTRL, 32'h0000_0101);
        bus(1'b0, hbs_pkg::REG_CTRL, 32'h0);
        check(rv, 32'h0A08_0101);
        bus(1'b0, hbs_pkg::REG_TIMING, 32'h0);
        check(rv, {hbs_pkg::RELEASE_DFLT_MS, 16'h0 - hbs_pkg::APPLY_DFLT_MS});
        bus(1'b1, hbs_pkg::REG_TIMING, 32'h0000_FFFF);
    endtask

    task automatic t_servo();
        set_in(1'b1, 1'b0);
        wait_on(2, 1'b1, c);
        check({mot, brk}, 2'b11);
        bus(1'b1, hbs_pkg::REG_DECEL, 32'h0000_0005);
        bus(1'b0, hbs_pkg::REG_DECEL, 32'h0);
        check(rv, {16'h0000, hbs_pkg::DECEL_DFLT_MS});
        set_in(1'b0, 1'b0);
        wait_on(3, 1'b1, c);
        check({brk, mot, mov}, 3'b110);
        check(dyn, 1'b1);
        wait_on(0, 1'b0, c);
        check(spd <= 8'h0A, 1'b1);
        wait_on(1, 1'b0, c);
        // Apply delay of -1 ms counts its magnitude
        check(c > 39990 && c < 40010, 1'b1);
    endtask

    task automatic t_quick();
        bus(1'b1, hbs_pkg::REG_CTRL, 32'h0A08_4701);
        bus(1'b1, hbs_pkg::REG_TIMING, 32'h0);
        set_in(1'b1, 1'b1);
        wait_on(1, 1'b1, c);
        set_in(1'b0, 1'b1);
        wait_on(3, 1'b1, c);
        check(dyn, 1'b0);
        wait_on(1, 1'b0, c);
        wait_on(5, 1'b1, c);
        check(c < 4, 1'b1);
        set_in(1'b1, 1'b1);
        repeat (20) @(posedge sys_clk_i);
        check(mot, 1'b0);
        set_in(1'b0, 1'b0);
        // Let the dropped input settle so the clear cannot re-enable
        repeat (8) @(posedge sys_clk_i);
        bus(1'b0, hbs_pkg::REG_STATUS, 32'h0);
        check(rv[7:6], 2'b10);
        bus(1'b1, hbs_pkg::REG_STATUS, 32'h0);
        bus(1'b0, hbs_pkg::REG_STATUS, 32'h0);
        check(rv[7], 1'b0);
    endtask

    task automatic t_hold();
        bus(1'b1, hbs_pkg::REG_CTRL, 32'h0A08_4801);
        set_in(1'b1, 1'b0);
        wait_on(1, 1'b1, c);
        check(brk, 1'b1);
        set_in(1'b0, 1'b0);
        wait_on(3, 1'b1, c);
        check({dyn, mot}, 2'b01);
        wait_on(1, 1'b0, c);
        check({alm, brk}, 2'b00);
    endtask

    task automatic t_coast();
        bus(1'b1, hbs_pkg::REG_CTRL, 32'h0A08_0103);
        set_in(1'b1, 1'b0);
        wait_on(2, 1'b1, c);
        set_in(1'b0, 1'b0);
        wait_on(3, 1'b1, c);
        check(dyn, 1'b0);
        wait_on(1, 1'b0, c);
        check(brk, 1'b0);
    endtask

    initial begin
        repeat (20) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_auto();
        t_servo();
        t_quick();
        t_hold();
        t_coast();
        report_and_stop();
    end
endmodule
`default_nettype wire
